// ### pkg/sbrg_pkg.sv
// Package with register map, field positions and divider constants for the baud generator.
// How it works
// - Receive and transmit may use different overflows.
// - Slow prescale transmit rate follows sixteen-bit reload.
// - Reload is high byte above low byte.
// - Divide-by-four prescale gives three times rate.
// - Mode value 0x20 selects eight-bit auto-reload.
// - Receive rate follows doubling, prescale, reload byte.
// - Doubling bit doubles the eight-bit path rate.
// - Writing 0x48 sets run and interrupt bits.
// - Cleared run bit stops eight-bit timer entirely.
// - Each selected overflow stream divides by sixteen.
// - Two control bits pick receive, transmit sources.
// - Baud mode reloads sixteen-bit count, no interrupt.
package sbrg_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] SBRG_MODE_OFS  = 8'h00;
    localparam logic [7:0] SBRG_CTRL_OFS  = 8'h04;
    localparam logic [7:0] SBRG_POWER_OFS = 8'h08;
    localparam logic [7:0] SBRG_PRESC_OFS = 8'h0c;
    localparam logic [7:0] SBRG_T16C_OFS  = 8'h10;
    localparam logic [7:0] SBRG_RLDH_OFS  = 8'h14;
    localparam logic [7:0] SBRG_RLDL_OFS  = 8'h18;
    localparam logic [7:0] SBRG_T8RLD_OFS = 8'h1c;
    localparam logic [7:0] SBRG_CNT16_OFS = 8'h20;
    localparam logic [7:0] SBRG_CNT8_OFS  = 8'h24;
    // Field positions.
    localparam int SBRG_GATE_BIT   = 7;
    localparam int SBRG_MODE_LSB   = 4;
    localparam int SBRG_RUN8_BIT   = 6;
    localparam int SBRG_EXT_INTERRUPT_ONE_LEVEL_BIT   = 3;
    localparam int SBRG_DOUBLE_BIT = 7;
    localparam int SBRG_T8SEL_BIT  = 4;
    localparam int SBRG_T16SEL_BIT = 5;
    localparam int SBRG_RXSRC_BIT  = 5;
    localparam int SBRG_TXSRC_BIT  = 4;
    localparam int SBRG_RUN16_BIT  = 2;
    // Eight-bit auto-reload mode code in the two-bit mode field.
    localparam logic [1:0] SBRG_MODE_AUTO8 = 2'h2;
    // Reset values of all registers.
    localparam logic [7:0]  SBRG_RST8  = 8'h00;
    localparam logic [15:0] SBRG_RST16 = 16'h0000;
    // Prescaler terminal counts: divide by 12 and divide by 4.
    localparam logic [3:0] SBRG_PRE_SLOW = 4'hb;
    localparam logic [3:0] SBRG_PRE_FAST = 4'h3;
    // Terminal count of the divide-by-16 bit clock counters.
    localparam logic [3:0] SBRG_BIT_LAST = 4'hf;
    localparam logic [15:0] SBRG_T16_TOP = 16'hffff;
    localparam logic [7:0]  SBRG_T8_TOP  = 8'hff;
endpackage

// ### hw/sbrg_top.sv
// Serial baud rate generator with two auto-reload timers and an APB register file.
`timescale 1ns/10ps
`default_nettype none
module sbrg_top
    import sbrg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_interrupt_one_level,
    output logic             tx_bit_clk,
    output logic             rx_bit_clk
);
    // Software visible registers.
    logic [7:0]  timer_mode_register;
    logic [7:0]  timer_control_register;
    logic [7:0]  power_control_register;
    logic [7:0]  clock_prescale_register;
    logic [7:0]  timer16_control_register;
    logic [7:0]  timer16_reload_high;
    logic [7:0]  timer16_reload_low;
    logic [7:0]  timer8_reload_byte;
    logic [15:0] timer16_count_pair;
    logic [7:0]  timer8_count;

    // Returns the prescaler terminal count for a clock select bit.
    function automatic logic [3:0] pre_limit(input logic fast);
        pre_limit = fast ? SBRG_PRE_FAST : SBRG_PRE_SLOW;
    endfunction

    // Bus phase decoding.
    // Offsets compare on the full byte address, so misaligned ones are refused.
    wire setup_ph = psel && !penable;
    wire wr_en    = psel && penable && pwrite;
    wire hit_mode  = (paddr == SBRG_MODE_OFS);
    wire hit_ctrl  = (paddr == SBRG_CTRL_OFS);
    wire hit_power = (paddr == SBRG_POWER_OFS);
    wire hit_presc = (paddr == SBRG_PRESC_OFS);
    wire hit_t16c  = (paddr == SBRG_T16C_OFS);
    wire hit_rldh  = (paddr == SBRG_RLDH_OFS);
    wire hit_rldl  = (paddr == SBRG_RLDL_OFS);
    wire hit_t8rld = (paddr == SBRG_T8RLD_OFS);
    wire hit_cnt16 = (paddr == SBRG_CNT16_OFS);
    wire hit_cnt8  = (paddr == SBRG_CNT8_OFS);
    wire mapped = hit_mode | hit_ctrl | hit_power | hit_presc | hit_t16c
                | hit_rldh | hit_rldl | hit_t8rld | hit_cnt16 | hit_cnt8;
    wire wr_cnt16 = wr_en && hit_cnt16;
    wire wr_cnt8  = wr_en && hit_cnt8;

    // Every access completes in its first access cycle.
    // Unmapped offsets answer with an error and change nothing.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Decoded control fields.
    // Field positions live in the package so software headers can share them.
    wire gate8   = timer_mode_register[SBRG_GATE_BIT];
    wire [1:0] mode8 = timer_mode_register[SBRG_MODE_LSB+:2];
    wire run8_bit = timer_control_register[SBRG_RUN8_BIT];
    wire dbl      = power_control_register[SBRG_DOUBLE_BIT];
    wire timer8_clock_select  = clock_prescale_register[SBRG_T8SEL_BIT];
    wire timer16_clock_select = clock_prescale_register[SBRG_T16SEL_BIT];
    wire rx_src16 = timer16_control_register[SBRG_RXSRC_BIT];
    wire transmit_clock_source_bit = timer16_control_register[SBRG_TXSRC_BIT];
    wire run16    = timer16_control_register[SBRG_RUN16_BIT];
    // Reload pair, high byte on top.
    wire [15:0] timer16_reload_value = {timer16_reload_high, timer16_reload_low};

    // The interrupt level only matters when gating is on; only mode 2 counts.
    // The level is used as it stands at the edge, with no synchroniser in front of it.
    wire run8 = run8_bit && (!gate8 || ext_interrupt_one_level)
              && (mode8 == SBRG_MODE_AUTO8);

    // Read data selection.
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_mode) begin
            rd_data[7:0] = timer_mode_register;
        end else if (hit_ctrl) begin
            rd_data[7:0] = timer_control_register;
        end else if (hit_power) begin
            rd_data[7:0] = power_control_register;
        end else if (hit_presc) begin
            rd_data[7:0] = clock_prescale_register;
        end else if (hit_t16c) begin
            rd_data[7:0] = timer16_control_register;
        end else if (hit_rldh) begin
            rd_data[7:0] = timer16_reload_high;
        end else if (hit_rldl) begin
            rd_data[7:0] = timer16_reload_low;
        end else if (hit_t8rld) begin
            rd_data[7:0] = timer8_reload_byte;
        end else if (hit_cnt16) begin
            rd_data[15:0] = timer16_count_pair;
        end else if (hit_cnt8) begin
            rd_data[7:0] = timer8_count;
        end
    end

    // Read data is captured in the setup cycle so it comes from a flop.
    // The trade: a running counter reads as it stood at the setup edge, one cycle old.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= rd_data;
        end
    end

    // Control register writes; a write of 0x48 to control sets run and level bits.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_mode_register      <= SBRG_RST8;
            timer_control_register   <= SBRG_RST8;
            power_control_register   <= SBRG_RST8;
            clock_prescale_register  <= SBRG_RST8;
            timer16_control_register <= SBRG_RST8;
        end else if (wr_en) begin
            if (hit_mode) timer_mode_register <= pwdata[7:0];
            if (hit_ctrl) timer_control_register <= pwdata[7:0];
            if (hit_power) power_control_register <= pwdata[7:0];
            if (hit_presc) clock_prescale_register <= pwdata[7:0];
            if (hit_t16c) timer16_control_register <= pwdata[7:0];
        end
    end

    // Reload register writes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer16_reload_high <= SBRG_RST8;
            timer16_reload_low  <= SBRG_RST8;
            timer8_reload_byte  <= SBRG_RST8;
        end else if (wr_en) begin
            if (hit_rldh) timer16_reload_high <= pwdata[7:0];
            if (hit_rldl) timer16_reload_low <= pwdata[7:0];
            if (hit_t8rld) timer8_reload_byte <= pwdata[7:0];
        end
    end

    // Prescalers: index 0 feeds the 16-bit timer, index 1 the 8-bit timer.
    logic [1:0] pre_fast;
    logic [1:0] pre_run;
    logic [1:0] tick;
    logic [3:0] pre_cnt [2];
    assign pre_fast = {timer8_clock_select, timer16_clock_select};
    assign pre_run  = {run8, run16};
    generate
        for (genvar i = 0; i < 2; i++) begin : g_pre
            // A stopped timer holds its prescaler at zero so it restarts aligned.
            // A prescale change mid-count can shorten one tick period, never lengthen it.
            wire at_lim = (pre_cnt[i] >= pre_limit(pre_fast[i]));
            assign tick[i] = pre_run[i] && at_lim;
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    pre_cnt[i] <= 4'h0;
                end else if (!pre_run[i] || at_lim) begin
                    pre_cnt[i] <= 4'h0;
                end else begin
                    pre_cnt[i] <= pre_cnt[i] + 4'h1;
                end
            end
        end
    endgenerate

    // 16-bit timer; it raises no interrupt, only the overflow pulse.
    // Software count writes win over counting, so a preset is never lost.
    wire ovf16 = tick[0] && (timer16_count_pair == SBRG_T16_TOP);
    wire [15:0] next_cnt16 = ovf16 ? timer16_reload_value
                                   : timer16_count_pair + 16'h0001;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer16_count_pair <= SBRG_RST16;
        end else if (wr_cnt16) begin
            timer16_count_pair <= pwdata[15:0];
        end else if (tick[0]) begin
            timer16_count_pair <= next_cnt16;
        end
    end

    // 8-bit timer in auto-reload mode.
    // Any other mode leaves the count frozen, since run8 is then low.
    wire ovf8 = tick[1] && (timer8_count == SBRG_T8_TOP);
    wire [7:0] next_cnt8 = ovf8 ? timer8_reload_byte
                                : timer8_count + 8'h01;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer8_count <= SBRG_RST8;
        end else if (wr_cnt8) begin
            timer8_count <= pwdata[7:0];
        end else if (tick[1]) begin
            timer8_count <= next_cnt8;
        end
    end

    // Without doubling every second 8-bit overflow passes on, halving the rate.
    // The halving flop toggles on every overflow, so its phase after a change is arbitrary.
    logic half8;
    wire t8_path = ovf8 && (dbl || half8);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half8 <= 1'b0;
        end else if (ovf8) begin
            half8 <= !half8;
        end
    end

    // Bit clock dividers: index 0 transmit, index 1 receive.
    // After a restart the first pulse comes a full sixteen overflows later.
    logic [1:0] src16;
    logic [1:0] src_q;
    logic [1:0] bclk;
    logic [3:0] bit_cnt [2];
    assign src16 = {rx_src16, transmit_clock_source_bit};
    generate
        for (genvar i = 0; i < 2; i++) begin : g_bit
            wire pulse_in = src16[i] ? ovf16 : t8_path;
            // A source change resets the count so no short period escapes.
            wire restart = (src16[i] != src_q[i]);
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    bit_cnt[i] <= 4'h0;
                    src_q[i]   <= 1'b0;
                    bclk[i]    <= 1'b0;
                end else begin
                    src_q[i] <= src16[i];
                    bclk[i]  <= pulse_in && !restart && (bit_cnt[i] == SBRG_BIT_LAST);
                    if (restart) begin
                        bit_cnt[i] <= 4'h0;
                    end else if (pulse_in) begin
                        bit_cnt[i] <= bit_cnt[i] + 4'h1;
                    end
                end
            end
        end
    endgenerate
    assign tx_bit_clk = bclk[0];
    assign rx_bit_clk = bclk[1];

    // Checks on the timing chain.
    // Reset disables them all; the bus side is left to the bench.
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    t16_reload_a: assert property (
        ovf16 && !wr_cnt16 |=> timer16_count_pair == $past(timer16_reload_value))
        else $error("16-bit timer did not reload on overflow.");
    t8_reload_a: assert property (
        ovf8 && !wr_cnt8 |=> timer8_count == $past(timer8_reload_byte))
        else $error("8-bit timer did not reload on overflow.");
    t8_stopped_a: assert property (
        (!run8_bit && !rx_src16)[*2] |-> !rx_bit_clk)
        else $error("Receive bit clock while 8-bit timer stopped.");
    // A stopped 8-bit timer keeps its count for software to read.
    t8_hold_a: assert property (
        !run8 && !wr_cnt8 |=> $stable(timer8_count))
        else $error("Stopped 8-bit timer changed its count.");
    gate_ignore_a: assert property (
        run8_bit && !gate8 && mode8 == SBRG_MODE_AUTO8 |=> pre_cnt[1] != $past(pre_cnt[1]))
        else $error("Ungated 8-bit timer not counting.");
    mode_only_a: assert property (
        tick[1] |-> mode8 == SBRG_MODE_AUTO8)
        else $error("8-bit timer ticked outside mode 2.");

    fast_gap_a: assert property (
        tick[0] |=> !tick[0] [*3])
        else $error("16-bit prescaler ticked too soon.");
    slow_gap_a: assert property (
        tick[0] && !timer16_clock_select |=> (!tick[0] || timer16_clock_select) [*8])
        else $error("Divide-by-12 prescaler ticked too soon.");

    bit_gap_a: assert property (
        tx_bit_clk |=> !tx_bit_clk [*8])
        else $error("Transmit bit clock pulses too close.");
    tx_src_a: assert property (
        tx_bit_clk |-> ($past(transmit_clock_source_bit) ? $past(ovf16) : $past(t8_path)))
        else $error("Transmit bit clock from wrong source.");
    // Receive side mirrors the transmit checks.
    rx_gap_a: assert property (
        rx_bit_clk |=> !rx_bit_clk [*8])
        else $error("Receive bit clock pulses too close.");
    rx_src_a: assert property (
        rx_bit_clk |-> ($past(rx_src16) ? $past(ovf16) : $past(t8_path)))
        else $error("Receive bit clock from wrong source.");
    restart_a: assert property (
        rx_src16 != $past(rx_src16) |=> !rx_bit_clk)
        else $error("Receive bit clock not restarted on source change.");
    halve_a: assert property (
        ovf8 && !dbl && !half8 |-> !t8_path)
        else $error("Undoubled 8-bit path passed every overflow.");

    // Main scenarios worth seeing in a run.
    tx_seen_c: cover property (tx_bit_clk);
    rx_seen_c: cover property (rx_bit_clk && !rx_src16);
    rx16_seen_c: cover property (rx_bit_clk && rx_src16);
    t16_ovf_c: cover property (ovf16 && timer16_clock_select);
    src_chg_c: cover property (transmit_clock_source_bit != $past(transmit_clock_source_bit));
endmodule
`default_nettype wire

// ### testbench/sbrg_serial_model.sv
// Stand-in for the serial shift logic that times the bit clock pulses it receives.
`timescale 1ns/10ps
`default_nettype none
module sbrg_serial_model (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic tx_bit_clk,
    input  wire logic rx_bit_clk,
    output var int    tx_period,
    output var int    rx_period,
    output var int    tx_count,
    output var int    rx_count
);
    int cyc;     // Free-running cycle index of the oscillator clock.
    int tx_last; // Index of the latest transmit pulse.
    int rx_last; // Index of the latest receive pulse.

    // Pulses are taken only on the rising edge, as the real shift logic would.
    // A period is the distance between the two latest pulses, so the first one is junk.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc       <= 0;
            tx_last   <= 0;
            rx_last   <= 0;
            tx_period <= 0;
            rx_period <= 0;
            tx_count  <= 0;
            rx_count  <= 0;
        end else begin
            cyc <= cyc + 1;
            // Transmit pulse seen: log its spacing.
            if (tx_bit_clk) begin
                tx_period <= cyc - tx_last;
                tx_last   <= cyc;
                tx_count  <= tx_count + 1;
            end
            // Receive pulse seen: log its spacing.
            if (rx_bit_clk) begin
                rx_period <= cyc - rx_last;
                rx_last   <= cyc;
                rx_count  <= rx_count + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/serial_baud_rate_generator_tb.sv
// Self-checking testbench for the serial baud rate generator.
`timescale 1ns/10ps
`default_nettype none
module serial_baud_rate_generator_tb;
    import sbrg_pkg::*;
    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        level;
    logic        tx_bit_clk;
    logic        rx_bit_clk;
    int          tx_period;
    int          rx_period;
    int          tx_count;
    int          rx_count;
    int          error_cnt = 0;
    int          compares  = 0;
    int          cycles    = 0;
    logic [31:0] rd;
    logic        err;
    int          n16;
    int          n8;

    sbrg_top dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_interrupt_one_level(level), .tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk));
    sbrg_serial_model far_end (.clk(clk), .arst_n(arst_n), .tx_bit_clk(tx_bit_clk),
        .rx_bit_clk(rx_bit_clk), .tx_period(tx_period), .rx_period(rx_period),
        .tx_count(tx_count), .rx_count(rx_count));

    // Period of a bit clock fed by the sixteen-bit timer, in oscillator cycles.
    function automatic int exp_t16(input int n, input bit fast);
        return 16 * n * (fast ? 4 : 12);
    endfunction
    // Without doubling only every second eight-bit overflow counts.
    function automatic int exp_t8(input int n, input bit fast, input bit dbl);
        return 16 * n * (fast ? 4 : 12) * (dbl ? 1 : 2);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Three fresh pulses flush any interval that straddles a setting change.
    task automatic wait_pulses(input bit tx, input int limit);
        int c0;
        int k;
        c0 = tx ? tx_count : rx_count;
        k  = 0;
        while (((tx ? tx_count : rx_count) < c0 + 3) && k < limit) begin
            @(posedge clk);
            k++;
        end
        // A limit that runs out is itself a mismatch.
        if ((tx ? tx_count : rx_count) < c0 + 3) begin
            error_cnt++;
            $display("unexpected %s pulse count: expected 3 seen %0d", tx ? "tx" : "rx",
                (tx ? tx_count : rx_count) - c0);
        end
    endtask

    // The window is longer than any receive period used here.
    task automatic expect_silent(input string what);
        int c0;
        repeat (5) @(posedge clk);
        c0 = rx_count;
        repeat (2500) @(posedge clk);
        check(what, c0, rx_count);
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        arst_n  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        level   = 1'b0;
        void'($urandom(63394));
        n16 = 1 + $urandom % 4;
        n8  = 1 + $urandom % 6;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // Every mapped register reads zero; the first unmapped word is refused.
        for (int a = 0; a <= 'h28; a += 4) begin
            apb(8'(a), 1'b0, 32'h0);
            check("reset read", 32'h0, rd);
            check("slave error", {31'h0, a == 'h28}, {31'h0, err});
        end
        $display("test register reset done");
        apb(SBRG_RLDH_OFS, 1'b1, 32'h0000_00ff);
        apb(SBRG_RLDL_OFS, 1'b1, 32'(256 - n16));
        apb(SBRG_CNT16_OFS, 1'b1, 32'h0000_ffff);
        apb(SBRG_T16C_OFS, 1'b1, 32'h0000_0014);
        for (int f = 0; f < 2; f++) begin
            apb(SBRG_PRESC_OFS, 1'b1, 32'(f << 5));
            wait_pulses(1'b1, 4000);
            check("tx period", exp_t16(n16, f[0]), tx_period);
        end
        apb(SBRG_RLDL_OFS, 1'b0, 32'h0);
        check("reload low", 32'(256 - n16), rd);
        apb(SBRG_T16C_OFS, 1'b0, 32'h0);
        check("source control", 32'h0000_0014, rd);
        $display("test transmit from sixteen-bit timer done");
        apb(SBRG_T8RLD_OFS, 1'b1, 32'(256 - n8));
        apb(SBRG_CNT8_OFS, 1'b1, 32'h0000_00ff);
        apb(SBRG_MODE_OFS, 1'b1, 32'h0000_0020);
        apb(SBRG_CTRL_OFS, 1'b1, 32'h0000_0048);
        // Both prescales and both doubling states, with the gate level held low.
        for (int m = 0; m < 4; m++) begin
            apb(SBRG_PRESC_OFS, 1'b1, 32'((m & 1) << 4));
            apb(SBRG_POWER_OFS, 1'b1, 32'((m >> 1) << 7));
            wait_pulses(1'b0, 8000);
            check("rx period", exp_t8(n8, m[0], m[1]), rx_period);
        end
        wait_pulses(1'b1, 4000);
        check("tx period", exp_t16(n16, 1'b0), tx_period);
        $display("test receive from eight-bit timer done");
        apb(SBRG_MODE_OFS, 1'b1, 32'h0000_00a0);
        expect_silent("rx pulses gated");
        level <= 1'b1;
        wait_pulses(1'b0, 8000);
        check("rx period gate open", exp_t8(n8, 1'b1, 1'b1), rx_period);
        apb(SBRG_CTRL_OFS, 1'b1, 32'h0000_0008);
        expect_silent("rx pulses stopped");
        apb(SBRG_CTRL_OFS, 1'b1, 32'h0000_0048);
        apb(SBRG_MODE_OFS, 1'b1, 32'h0000_0010);
        expect_silent("rx pulses wrong mode");
        apb(SBRG_MODE_OFS, 1'b1, 32'h0000_00a0);
        $display("test gate and run bit done");
        apb(SBRG_T16C_OFS, 1'b1, 32'h0000_0024);
        wait_pulses(1'b1, 8000);
        check("tx from eight-bit", exp_t8(n8, 1'b1, 1'b1), tx_period);
        wait_pulses(1'b0, 8000);
        check("rx from sixteen-bit", exp_t16(n16, 1'b0), rx_period);
        $display("test swapped sources done");
        finish_test();
    end
endmodule
`default_nettype wire
